// [design/pic_pkg.sv]
// constants shared by the peripheral interrupt vectoring block
// assumes a 16-bit data memory port on the core side
package pic_pkg;
	localparam int          NUM_SRC       = 11;
	localparam int          IDX_W         = 4;
	localparam logic [15:0] ADDR_VECTOR   = 16'h201C;
	localparam logic [15:0] ADDR_MASK     = 16'h201D;
	localparam logic [10:0] MASK_RESET    = 11'h000;
	localparam logic [15:0] VEC_BASE      = 16'h0030;
	localparam logic [15:0] VEC_LAST      = 16'h0058;
	localparam logic [15:0] VEC_STEP      = 16'h0004;
	localparam logic [15:0] VEC_RESET     = 16'h0000;
	// source bit positions, ascending vector and falling priority
	localparam int          SRC_ADC_EOC   = 0;
	localparam int          SRC_PWM_SYNC  = 1;
	localparam int          SRC_LOOP_TMO  = 2;
	localparam int          SRC_PIO_HIGH  = 3;
	localparam int          SRC_CNT_ERR   = 4;
	localparam int          SRC_EVT_TIMER = 5;
	localparam int          SRC_PIO0      = 6;
	localparam int          SRC_PWM_TRIP  = 10;
	localparam int          PIO_LINES     = 12;
	localparam int          PIO_OWN       = 4;

	function automatic logic [15:0] vec_of(input logic [IDX_W-1:0] idx);
		return VEC_BASE + VEC_STEP * {12'h000, idx};
	endfunction

	function automatic logic [NUM_SRC-1:0] onehot(input logic [IDX_W-1:0] idx);
		return NUM_SRC'(1) << idx;
	endfunction
endpackage

// [design/pick_if.sv]
// carrier between the controller and its priority picker
// assumes both ends share one clock domain
`timescale 1ns/1ps
interface pick_if #(parameter int N = 11, parameter int W = 4);
	logic [N-1:0] cand;
	logic         valid;
	logic [W-1:0] index;
	modport ctrl (output cand, input valid, input index);
	modport picker (input cand, output valid, output index);
endinterface

// [design/priority_pick.sv]
// fixed priority picker: lowest set bit wins
// assumes a purely combinational use inside one clock domain
`timescale 1ns/1ps
module priority_pick #(
	parameter int N = 11,
	parameter int W = 4
) (
	pick_if.picker p
);
	if (N > (1 << W)) begin : g_chk
		$error("priority_pick: index too narrow for N");
	end

	always_comb begin
		p.valid = 1'b0;
		p.index = '0;
		// scanning downward lets the lowest index overwrite last
		for (int i = N - 1; i >= 0; i--) begin
			if (p.cand[i]) begin
				p.valid = 1'b1;
				p.index = W'(i);
			end
		end
	end
endmodule // priority_pick

// [design/peripheral_irq_ctrl.sv]
// peripheral interrupt vectoring controller in front of the core
// assumes event inputs are one-cycle pulses from logic on sys_clk
// Function
// - enabled source pulls request line low
// - vectors 0x30 to 0x58, four apart
// - fixed vector per source as listed
// - lower vector means higher priority
// - pointer loads highest pending enabled source
// - sources raised meanwhile tracked for next service
// - presented vector held until read
// - new request only after pointer read
// - more pending at read keeps line low
// - pio 0-3 own vectors, 4-11 shared
// - eleven-bit mask enables each source
// - mask resets to zero
`timescale 1ns/1ps
module peripheral_irq_ctrl
(
	// clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          reset,
	// core data memory access
	input  wire logic [15:0]                   reg_addr,
	input  wire logic                          reg_rd,
	input  wire logic                          reg_wr,
	input  wire logic [15:0]                   reg_wdata,
	output logic      [15:0]                   reg_rdata,
	// peripheral event pulses
	input  wire logic                          adc_eoc,
	input  wire logic                          pwm_sync_event,
	input  wire logic                          loop_timeout,
	input  wire logic                          count_error,
	input  wire logic                          event_timer,
	input  wire logic                          pwm_trip,
	input  wire logic [pic_pkg::PIO_LINES-1:0] pio_line_irq,
	// request to the core, active low
	output logic                               peripheral_request_n
);
	import pic_pkg::*;

	logic [NUM_SRC-1:0] source_enable_mask;
	logic [NUM_SRC-1:0] pending;
	logic [15:0]        vector_pointer;
	logic [IDX_W-1:0]   cur_idx;
	logic [NUM_SRC-1:0] events;
	logic [NUM_SRC-1:0] next_pending;
	logic               rd_vec;
	logic               wr_mask;
	logic               served;

	pick_if #(.N(NUM_SRC), .W(IDX_W)) pk ();

	priority_pick #(.N(NUM_SRC), .W(IDX_W)) u_pick (
		.p (pk.picker)
	);

	assign rd_vec  = reg_rd && reg_addr == ADDR_VECTOR;
	assign wr_mask = reg_wr && reg_addr == ADDR_MASK;
	// a read only retires a source while one is actually presented
	assign served  = rd_vec && !peripheral_request_n;

	always_comb begin
		events                = '0;
		events[SRC_ADC_EOC]   = adc_eoc;
		events[SRC_PWM_SYNC]  = pwm_sync_event;
		events[SRC_LOOP_TMO]  = loop_timeout;
		events[SRC_PIO_HIGH]  = |pio_line_irq[PIO_LINES-1:PIO_OWN];
		events[SRC_CNT_ERR]   = count_error;
		events[SRC_EVT_TIMER] = event_timer;
		events[SRC_PIO0 +: PIO_OWN] = pio_line_irq[PIO_OWN-1:0];
		events[SRC_PWM_TRIP]  = pwm_trip;
	end

	// new events win over the clear caused by the pointer read
	assign next_pending = (pending & ~(served ? onehot(cur_idx) : '0)) | events;
	assign pk.cand      = next_pending & source_enable_mask;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			source_enable_mask <= MASK_RESET;
		end else if (wr_mask) begin
			source_enable_mask <= reg_wdata[NUM_SRC-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pending <= '0;
		end else begin
			pending <= next_pending;
		end
	end

	// the request only re-evaluates when idle or on the serving read
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			peripheral_request_n <= 1'b1;
		end else if (peripheral_request_n || rd_vec) begin
			peripheral_request_n <= !pk.valid;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			vector_pointer <= VEC_RESET;
			cur_idx        <= '0;
		end else if ((peripheral_request_n || rd_vec) && pk.valid) begin
			vector_pointer <= vec_of(pk.index);
			cur_idx        <= pk.index;
		end
	end

	// one cycle read latency; unmapped addresses read zero
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			reg_rdata <= 16'h0000;
		end else if (rd_vec) begin
			reg_rdata <= vector_pointer;
		end else if (reg_rd && reg_addr == ADDR_MASK) begin
			reg_rdata <= {5'h00, source_enable_mask};
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	AST_REQ_ON_PENDING:
	assert property (@(posedge sys_clk) disable iff (reset)
		(peripheral_request_n && pk.valid) |=> !peripheral_request_n)
		else $error("enabled pending source did not raise the request");

	AST_VEC_RANGE:
	assert property (@(posedge sys_clk) disable iff (reset)
		!peripheral_request_n |-> (vector_pointer >= VEC_BASE
			&& vector_pointer <= VEC_LAST && vector_pointer[1:0] == 2'b00))
		else $error("presented vector outside the peripheral slots");

	AST_VEC_ENCODE:
	assert property (@(posedge sys_clk) disable iff (reset)
		$fell(peripheral_request_n) && $past(events[SRC_ADC_EOC] && source_enable_mask[0])
		|-> vector_pointer == VEC_BASE)
		else $error("converter source not presented at the top vector");

	AST_PRIORITY:
	assert property (@(posedge sys_clk) disable iff (reset)
		$fell(peripheral_request_n) |->
		($past(pk.cand) & (onehot(cur_idx) - NUM_SRC'(1))) == '0)
		else $error("a higher priority source was passed over");

	AST_LOAD_WINNER:
	assert property (@(posedge sys_clk) disable iff (reset)
		(rd_vec && !peripheral_request_n && pk.valid) |=>
		(!peripheral_request_n && vector_pointer == vec_of($past(pk.index))))
		else $error("pointer not loaded with the next winner after read");

	AST_TRACK_NEW:
	assert property (@(posedge sys_clk) disable iff (reset)
		(!peripheral_request_n && !rd_vec && |(events & source_enable_mask))
		|=> pending != '0)
		else $error("event raised during service was lost");

	AST_VEC_STABLE:
	assert property (@(posedge sys_clk) disable iff (reset)
		(!peripheral_request_n && !rd_vec) |=> $stable(vector_pointer))
		else $error("presented vector changed before the read");

	AST_NO_NEW_WITHOUT_READ:
	assert property (@(posedge sys_clk) disable iff (reset)
		(!peripheral_request_n && !rd_vec) |=> !peripheral_request_n)
		else $error("request dropped without a pointer read");

	AST_RISE_ON_READ:
	assert property (@(posedge sys_clk) disable iff (reset)
		$rose(peripheral_request_n) |-> $past(rd_vec))
		else $error("request released without a pointer read");

	AST_HOLD_LOW:
	assert property (@(posedge sys_clk) disable iff (reset)
		(served && |(pending & source_enable_mask & ~onehot(cur_idx)))
		|=> !peripheral_request_n)
		else $error("request line bounced with work still pending");

	AST_PIO_SHARED:
	assert property (@(posedge sys_clk) disable iff (reset)
		|pio_line_irq[PIO_LINES-1:PIO_OWN] |=> pending[SRC_PIO_HIGH])
		else $error("upper pio line did not raise the shared source");

	AST_MASK_WRITE:
	assert property (@(posedge sys_clk) disable iff (reset)
		wr_mask |=> source_enable_mask == $past(reg_wdata[NUM_SRC-1:0]))
		else $error("mask write not taken");

	AST_MASK_RESET:
	assert property (@(posedge sys_clk)
		$past(reset) |-> source_enable_mask == '0)
		else $error("mask not cleared by reset");

	AST_MASKED_SILENT:
	assert property (@(posedge sys_clk) disable iff (reset)
		(peripheral_request_n && ((pending | events) & source_enable_mask) == '0)
		|=> peripheral_request_n)
		else $error("masked source raised the request");

	AST_RELEASE:
	assert property (@(posedge sys_clk) disable iff (reset)
		(served && !pk.valid) |=> peripheral_request_n)
		else $error("request not released after last read");
endmodule // peripheral_irq_ctrl

// [tb/core_model.sv]
// model of the core sequencer servicing the peripheral request line
// assumes strobes launched on the falling edge of sys_clk, pointer at ADDR_VECTOR
`timescale 1ns/1ps
module core_model
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// request side
	input  wire logic        peripheral_request_n,
	input  wire logic        irq_en,
	input  wire logic [3:0]  delay,
	input  wire logic [15:0] reg_rdata,
	// handler actions
	output logic             ptr_rd,
	output logic             got,
	output logic [15:0]      vec
);
	import pic_pkg::*;

	int   cnt;
	logic wait_d;
	// level sensitive: a line held low is serviced again, so nothing is lost
	always @(negedge sys_clk) begin
		got    <= 1'b0;
		ptr_rd <= 1'b0;
		if (reset) begin
			cnt    <= 0;
			wait_d <= 1'b0;
		end else if (wait_d) begin
			wait_d <= 1'b0;
			got    <= 1'b1;
			vec    <= reg_rdata;
		end else if (irq_en && !peripheral_request_n) begin
			cnt <= cnt + 1;
			if (cnt >= delay) begin
				cnt    <= 0;
				ptr_rd <= 1'b1;
				wait_d <= 1'b1;
			end
		end
	end
endmodule // core_model

// [tb/peripheral_irq_ctrl_tb_top.sv]
// self-checking bench for the peripheral interrupt vectoring controller
// assumes core_model answers the request by reading the pointer
`timescale 1ns/1ps
module peripheral_irq_ctrl_tb_top;
	import pic_pkg::*;
	logic sys_clk = 0, reset = 1, tb_rd = 0, reg_wr = 0, irq_en = 0, ptr_rd, got;
	logic [15:0] tb_addr = 0, reg_wdata = 0, reg_rdata, vec, rnd = 16'h0046, rv;
	logic [10:0] ev = 0, pend = 0, mask = 0;
	logic [3:0]  delay = 0;
	logic [11:0] parallel_io;
	logic req_n;
	int miscompares = 0, comparisons = 0, cycles = 0, k, i;
	wire rd = tb_rd | (ptr_rd === 1'b1);
	wire [15:0] addr = (ptr_rd === 1'b1) ? ADDR_VECTOR : tb_addr;
	always #5 sys_clk = ~sys_clk;
	peripheral_irq_ctrl uut (.sys_clk(sys_clk), .reset(reset), .reg_addr(addr), .reg_rd(rd),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_eoc(ev[0]),
		.pwm_sync_event(ev[1]), .loop_timeout(ev[2]), .count_error(ev[4]), .event_timer(ev[5]),
		.pwm_trip(ev[10]), .pio_line_irq(parallel_io), .peripheral_request_n(req_n));
	core_model core (.sys_clk(sys_clk), .reset(reset), .peripheral_request_n(req_n),
		.irq_en(irq_en), .delay(delay), .reg_rdata(reg_rdata), .ptr_rd(ptr_rd), .got(got),
		.vec(vec));
	// the shared pio source may come from any of the eight upper lines
	assign parallel_io = {ev[3] ? 8'(1 << rnd[2:0]) : 8'h00, ev[9:6]};
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic chk(input logic [15:0] got_v, input logic [15:0] exp_v);
		comparisons++;
		if (got_v !== exp_v) begin
			miscompares++;
			$display("ERROR %0t: got %h expected %h", $time, got_v, exp_v);
		end
	endtask
	task automatic complete_run;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge sys_clk) {reg_wr, tb_addr, reg_wdata} = {1'b1, a, d};
		@(negedge sys_clk) reg_wr = 0;
	endtask
	task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
		@(negedge sys_clk) {tb_rd, tb_addr} = {1'b1, a};
		@(negedge sys_clk) tb_rd = 0;
		d = reg_rdata;
	endtask
	// winning vector of the live sources, zero when none is live
	function automatic logic [15:0] win(input logic [10:0] live);
		win = 16'h0000;
		for (int j = 10; j >= 0; j--)
			if (live[j])
				win = 16'h0030 + 16'(4 * j);
	endfunction
	// new mask first, events while a vector may already stand, then serve everything enabled
	task automatic burst(input logic [10:0] m, input logic [10:0] e);
		irq_en = 0;
		wr(ADDR_MASK, {5'h00, m});
		mask = m;
		rv = win(pend & mask);
		@(negedge sys_clk) ev = e;
		@(negedge sys_clk) ev = 0;
		pend = pend | e;
		// a vector already shown stays put although a higher source arrived
		if (rv == 16'h0000)
			rv = win(pend & mask);
		irq_en = 1;
		for (k = 0; k < 300; k++) begin
			@(posedge sys_clk);
			if (got === 1'b1) begin
				chk(vec, rv);
				for (i = 0; i < 11; i++)
					if (rv == 16'h0030 + 16'(4 * i))
						pend[i] = 1'b0;
				rv = win(pend & mask);
				chk(16'(req_n), 16'(rv == 16'h0000));
				delay = rnd[7:4];
			end
		end
		chk(16'(req_n), 16'((pend & mask) == 11'h000));
		$display("burst mask %h events %h done", m, e);
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 20000) begin
			miscompares++;
			complete_run;
		end
	end
	always @(negedge sys_clk)
		rnd <= lfsr(rnd);
	initial begin
		repeat (16) @(negedge sys_clk);
		reset = 0;
		rd_reg(ADDR_MASK, rv);
		chk(rv, {5'h00, MASK_RESET});
		wr(ADDR_MASK, 16'hFFFF);
		rd_reg(ADDR_MASK, rv);
		chk(rv, 16'h07FF);
		rd_reg(16'h2000, rv);
		chk(rv, 16'h0000);
		$display("register test done");
		burst(11'h000, 11'h7FF);
		burst(11'h7FF, 11'h000);
		burst(11'h401, 11'h401);
		for (int n = 0; n < 20; n++)
			burst(rnd[10:0] ^ 11'h155, 11'(lfsr(rnd)));
		complete_run;
	end
endmodule // peripheral_irq_ctrl_tb_top
